// file: verilog/sfr_address_extension_map.sv
// SFR decoder and register map with area mapping and port paging
//
// Behaviour
// - Only direct addresses 80h to FFh are decoded as SFRs.
// - Every core register but the program counter is reachable in the SFR range.
// - A standard and a mapped area each span 80h to FFh, giving 256 locations.
// - Area choice comes only from the map-select bit in the control register at 8Fh.
// - Map-select bit 0 at 1 reaches the mapped area, at 0 the standard area.
// - Control bit 2 reads back as last written and software writes it as 1.
// - Control bits 1 and 7 to 3 read as zero and software writes zeros there.
// - Watchdog registers at BBh to BFh answer only while map-select is 1.
// - Port registers answer only while map-select is 0.
// - The page register at B2h picks data/direction on page 0, pulls on page 1.
`timescale 1ns/10ps
`default_nettype none
module sfr_address_extension_map
  import sfr_map_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire sfr_req_s SFR_REQ,
  input wire logic EXT_HIT,
  input wire logic [7:0] EXT_RDATA,
  input wire logic [15:0] WDT_COUNT,
  input wire logic WDT_PREWARN,
  input wire logic MON_STATUS_SEL,
  input wire logic [7:0] MON_RX_DATA,
  output logic [7:0] SFR_RDATA,
  output logic SFR_MAP_SELECT,
  output logic [PORT_REG_COUNT*8-1:0] PORT_REGS,
  output wdt_cfg_s WDT_CFG,
  output logic WDT_REFRESH,
  output logic [7:0] MON_CONTROL,
  output logic [7:0] BP_SELECT,
  output logic [7:0] BP_DATA
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic area_hit(
    input logic [7:0] addr,
    input logic [7:0] offset,
    input logic map_now,
    input logic map_want
  );
    logic in_range;
    in_range = (addr >= SFR_BASE) && (addr <= SFR_LAST);
    return in_range && (addr == offset) && (map_now == map_want);
  endfunction : area_hit

  function automatic logic any_hit(input logic [7:0] addr, input logic [7:0] offset);
    return (addr >= SFR_BASE) && (addr == offset);
  endfunction : any_hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] syscon_reg;
  logic [2:0] page_reg;
  logic [2:0] page_next;
  logic [2:0] slot_reg [SLOT_COUNT];
  logic wdt_enable_reg;
  logic wdt_prescale_reg;
  logic wdt_refresh_reg;
  logic [7:0] mon_ctrl_reg;
  logic [7:0] bp_sel_reg;
  logic [7:0] rdata_reg;

  logic map_sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [1:0] page_op;
  logic [1:0] page_slot;

  assign addr = SFR_REQ.addr;
  assign wdata = SFR_REQ.wdata;
  assign wr = SFR_REQ.wr;
  assign map_sel = syscon_reg[MAP_SELECT_BIT];
  assign page_op = wdata[OP_LSB +: 2];
  assign page_slot = wdata[SLOT_LSB +: 2];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic sel_syscon;
  logic sel_page;
  logic sel_wdt_ctrl;
  logic sel_wdt_reload;
  logic sel_wdt_window;
  logic sel_wdt_lo;
  logic sel_wdt_hi;
  logic sel_mon_ctrl;
  logic sel_mon_data;
  logic sel_bp_sel;
  logic sel_bp_data;
  logic [PORT_REG_COUNT-1:0] sel_port;

  // Control register answers in both areas so the map can be switched back
  assign sel_syscon = any_hit(addr, SYSCON_OFF);
  assign sel_page = area_hit(addr, PAGE_OFF, map_sel, 1'b0);
  assign sel_wdt_ctrl = area_hit(addr, WDT_CTRL_OFF, map_sel, 1'b1);
  assign sel_wdt_reload = area_hit(addr, WDT_RELOAD_OFF, map_sel, 1'b1);
  assign sel_wdt_window = area_hit(addr, WDT_WINDOW_OFF, map_sel, 1'b1);
  assign sel_wdt_lo = area_hit(addr, WDT_CNT_LO_OFF, map_sel, 1'b1);
  assign sel_wdt_hi = area_hit(addr, WDT_CNT_HI_OFF, map_sel, 1'b1);
  assign sel_mon_ctrl = any_hit(addr, MON_CTRL_OFF);
  assign sel_mon_data = any_hit(addr, MON_DATA_OFF);
  assign sel_bp_sel = any_hit(addr, BP_SEL_OFF);
  assign sel_bp_data = any_hit(addr, BP_DATA_OFF);

  always_comb begin
    for (int i = 0; i < PORT_REG_COUNT; i++) begin
      sel_port[i] = area_hit(addr, PORT_OFFSET[i], map_sel, 1'b0) &&
                    (page_reg == PORT_PAGE_OF[i]);
    end
  end

  // ----------------------------------------------------------------
  // System control register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      syscon_reg <= SYSCON_RESET;
    end else if (wr && sel_syscon) begin
      syscon_reg <= wdata & SYSCON_RW_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Port page with save and restore slots
  // ----------------------------------------------------------------
  always_comb begin
    page_next = page_reg;
    if (wr && sel_page) begin
      if (page_op == OP_RESTORE) begin
        page_next = slot_reg[page_slot];
      end else begin
        page_next = wdata[PAGE_LSB +: 3];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      page_reg <= PAGE_RESET;
    end else begin
      page_reg <= page_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      for (int s = 0; s < SLOT_COUNT; s++) begin
        slot_reg[s] <= PAGE_RESET;
      end
    end else if (wr && sel_page && page_op == OP_STORE) begin
      slot_reg[page_slot] <= page_reg;
    end
  end

  // ----------------------------------------------------------------
  // Port data, direction and pull registers
  // ----------------------------------------------------------------
  logic [7:0] port_value [PORT_REG_COUNT];

  for (genvar g = 0; g < PORT_REG_COUNT; g++) begin : g_port
    sfr_byte_reg #(
      .RESET_VALUE(PORT_RESET[g]),
      .WRITE_MASK(PORT_MASK[g]),
      .FILL(PORT_FILL[g])
    ) u_port_reg (
      .CLOCK(CLOCK),
      .RST(RST),
      .WR(wr && sel_port[g]),
      .WDATA(wdata),
      .VALUE(port_value[g])
    );
    assign PORT_REGS[g*8 +: 8] = port_value[g];
  end

  // ----------------------------------------------------------------
  // Watchdog control, reload and window
  // ----------------------------------------------------------------
  logic [7:0] wdt_reload_value;
  logic [7:0] wdt_window_value;
  logic [7:0] wdt_ctrl_value;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wdt_enable_reg <= WDT_CTRL_RESET[WDT_ENABLE_BIT];
      wdt_prescale_reg <= WDT_CTRL_RESET[WDT_PRESCALE_BIT];
    end else if (wr && sel_wdt_ctrl) begin
      wdt_enable_reg <= wdata[WDT_ENABLE_BIT];
      wdt_prescale_reg <= wdata[WDT_PRESCALE_BIT];
    end
  end

  // Refresh request is a one-cycle strobe that clears itself
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wdt_refresh_reg <= WDT_CTRL_RESET[WDT_REFRESH_BIT];
    end else begin
      wdt_refresh_reg <= wr && sel_wdt_ctrl && wdata[WDT_REFRESH_BIT];
    end
  end

  sfr_byte_reg #(
    .RESET_VALUE(WDT_RELOAD_RESET),
    .WRITE_MASK(FULL_MASK),
    .FILL(NO_FILL)
  ) u_wdt_reload (
    .CLOCK(CLOCK),
    .RST(RST),
    .WR(wr && sel_wdt_reload),
    .WDATA(wdata),
    .VALUE(wdt_reload_value)
  );

  sfr_byte_reg #(
    .RESET_VALUE(WDT_WINDOW_RESET),
    .WRITE_MASK(FULL_MASK),
    .FILL(NO_FILL)
  ) u_wdt_window (
    .CLOCK(CLOCK),
    .RST(RST),
    .WR(wr && sel_wdt_window),
    .WDATA(wdata),
    .VALUE(wdt_window_value)
  );

  always_comb begin
    wdt_ctrl_value = 8'h00;
    wdt_ctrl_value[WDT_PRESCALE_BIT] = wdt_prescale_reg;
    wdt_ctrl_value[WDT_REFRESH_BIT] = wdt_refresh_reg;
    wdt_ctrl_value[WDT_ENABLE_BIT] = wdt_enable_reg;
    wdt_ctrl_value[WDT_PREWARN_BIT] = WDT_PREWARN;
  end

  // ----------------------------------------------------------------
  // Monitor control with guarded enables
  // ----------------------------------------------------------------
  logic [7:0] mon_ctrl_value;
  logic [7:0] bp_data_value;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mon_ctrl_reg <= MON_CTRL_RESET;
    end else if (wr && sel_mon_ctrl) begin
      mon_ctrl_reg <= (mon_ctrl_reg & ~MON_PLAIN_MASK) | (wdata & MON_PLAIN_MASK);
      if (wdata[MON_UIE_GUARD_BIT]) begin
        mon_ctrl_reg[MON_UIE_BIT] <= wdata[MON_UIE_BIT];
      end
      if (wdata[MON_RIE_GUARD_BIT]) begin
        mon_ctrl_reg[MON_RIE_BIT] <= wdata[MON_RIE_BIT];
      end
    end
  end

  always_comb begin
    mon_ctrl_value = mon_ctrl_reg & (MON_PLAIN_MASK | 8'h05);
    mon_ctrl_value[MON_STATUS_BIT] = MON_STATUS_SEL;
  end

  // ----------------------------------------------------------------
  // Breakpoint select and data
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bp_sel_reg <= BP_SEL_RESET;
    end else if (wr && sel_bp_sel && wdata[BP_SEL_GUARD_BIT]) begin
      bp_sel_reg <= wdata & BP_SEL_MASK;
    end
  end

  sfr_byte_reg #(
    .RESET_VALUE(BP_DATA_RESET),
    .WRITE_MASK(FULL_MASK),
    .FILL(NO_FILL)
  ) u_bp_data (
    .CLOCK(CLOCK),
    .RST(RST),
    .WR(wr && sel_bp_data),
    .WDATA(wdata),
    .VALUE(bp_data_value)
  );

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [7:0] read_value;
  logic own_hit;

  always_comb begin
    read_value = 8'h00;
    own_hit = 1'b1;
    if (sel_syscon) begin
      read_value = syscon_reg & SYSCON_RW_MASK;
    end else if (sel_page) begin
      read_value = {5'h00, page_reg};
    end else if (sel_wdt_ctrl) begin
      read_value = wdt_ctrl_value;
    end else if (sel_wdt_reload) begin
      read_value = wdt_reload_value;
    end else if (sel_wdt_window) begin
      read_value = wdt_window_value;
    end else if (sel_wdt_lo) begin
      read_value = WDT_COUNT[7:0];
    end else if (sel_wdt_hi) begin
      read_value = WDT_COUNT[15:8];
    end else if (sel_mon_ctrl) begin
      read_value = mon_ctrl_value;
    end else if (sel_mon_data) begin
      read_value = MON_RX_DATA;
    end else if (sel_bp_sel) begin
      read_value = bp_sel_reg & BP_SEL_MASK;
    end else if (sel_bp_data) begin
      read_value = bp_data_value;
    end else if (|sel_port) begin
      for (int i = 0; i < PORT_REG_COUNT; i++) begin
        if (sel_port[i]) begin
          read_value = port_value[i];
        end
      end
    end else begin
      own_hit = 1'b0;
    end
  end

  // Core registers live in the core; their data joins here
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_reg <= 8'h00;
    end else if (SFR_REQ.rd) begin
      if (own_hit) begin
        rdata_reg <= read_value;
      end else if (EXT_HIT && addr >= SFR_BASE) begin
        rdata_reg <= EXT_RDATA;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SFR_RDATA = rdata_reg;
  assign SFR_MAP_SELECT = map_sel;
  assign WDT_CFG.enable = wdt_enable_reg;
  assign WDT_CFG.prescale = wdt_prescale_reg;
  assign WDT_CFG.reload = wdt_reload_value;
  assign WDT_CFG.window = wdt_window_value;
  assign WDT_REFRESH = wdt_refresh_reg;
  assign MON_CONTROL = mon_ctrl_value;
  assign BP_SELECT = bp_sel_reg & BP_SEL_MASK;
  assign BP_DATA = bp_data_value;

endmodule : sfr_address_extension_map
`default_nettype wire

// file: verilog/sfr_map_pkg.sv
// Constants, layouts and carrier types of the SFR address extension map
package sfr_map_pkg;

  // ----------------------------------------------------------------
  // Bus widths and direct range
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] SFR_LAST = 8'hff;

  // ----------------------------------------------------------------
  // System control register
  // ----------------------------------------------------------------
  localparam logic [7:0] SYSCON_OFF = 8'h8f;
  localparam logic [7:0] SYSCON_RESET = 8'h04;
  localparam int MAP_SELECT_BIT = 0;
  localparam int KEEP_ONE_BIT = 2;
  localparam logic [7:0] SYSCON_RW_MASK = 8'h05;

  // ----------------------------------------------------------------
  // Port page register
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_OFF = 8'hb2;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam int PAGE_LSB = 0;
  localparam int SLOT_LSB = 3;
  localparam int OP_LSB = 6;
  localparam int SLOT_COUNT = 4;
  localparam logic [1:0] OP_STORE = 2'h2;
  localparam logic [1:0] OP_RESTORE = 2'h3;

  // ----------------------------------------------------------------
  // Port register table: data/direction on page 0, pulls on page 1
  // ----------------------------------------------------------------
  localparam int PORT_REG_COUNT = 12;
  localparam logic [7:0] PORT_OFFSET [PORT_REG_COUNT] = '{
    8'h80, 8'h86, 8'h90, 8'h91, 8'ha0, 8'ha1, 8'hb0, 8'hb1,
    8'h80, 8'h86, 8'h90, 8'h91};
  localparam logic [2:0] PORT_PAGE_OF [PORT_REG_COUNT] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h1, 3'h1, 3'h1, 3'h1};
  localparam logic [7:0] PORT_MASK [PORT_REG_COUNT] = '{
    8'h3f, 8'h3f, 8'h03, 8'h03, 8'h87, 8'h87, 8'h03, 8'h03,
    8'h3f, 8'h3f, 8'h03, 8'h03};
  localparam logic [7:0] PORT_FILL [PORT_REG_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hc0, 8'hc0, 8'hfc, 8'hfc};
  localparam logic [7:0] PORT_RESET [PORT_REG_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hff, 8'hc4, 8'hff, 8'hff};

  // ----------------------------------------------------------------
  // Watchdog group, mapped area
  // ----------------------------------------------------------------
  localparam logic [7:0] WDT_CTRL_OFF = 8'hbb;
  localparam logic [7:0] WDT_RELOAD_OFF = 8'hbc;
  localparam logic [7:0] WDT_WINDOW_OFF = 8'hbd;
  localparam logic [7:0] WDT_CNT_LO_OFF = 8'hbe;
  localparam logic [7:0] WDT_CNT_HI_OFF = 8'hbf;
  localparam logic [7:0] WDT_CTRL_RESET = 8'h00;
  localparam logic [7:0] WDT_RELOAD_RESET = 8'h00;
  localparam logic [7:0] WDT_WINDOW_RESET = 8'h00;
  localparam int WDT_PRESCALE_BIT = 0;
  localparam int WDT_REFRESH_BIT = 1;
  localparam int WDT_ENABLE_BIT = 2;
  localparam int WDT_PREWARN_BIT = 4;

  // ----------------------------------------------------------------
  // Monitor and breakpoint registers
  // ----------------------------------------------------------------
  localparam logic [7:0] MON_CTRL_OFF = 8'hf4;
  localparam logic [7:0] MON_DATA_OFF = 8'hf5;
  localparam logic [7:0] BP_SEL_OFF = 8'hf6;
  localparam logic [7:0] BP_DATA_OFF = 8'hf7;
  localparam logic [7:0] MON_CTRL_RESET = 8'h00;
  localparam logic [7:0] BP_SEL_RESET = 8'h00;
  localparam logic [7:0] BP_DATA_RESET = 8'h00;
  localparam logic [7:0] MON_PLAIN_MASK = 8'he0;
  localparam int MON_STATUS_BIT = 4;
  localparam int MON_UIE_GUARD_BIT = 3;
  localparam int MON_UIE_BIT = 2;
  localparam int MON_RIE_GUARD_BIT = 1;
  localparam int MON_RIE_BIT = 0;
  localparam int BP_SEL_GUARD_BIT = 3;
  localparam logic [7:0] BP_SEL_MASK = 8'h07;
  localparam logic [7:0] FULL_MASK = 8'hff;
  localparam logic [7:0] NO_FILL = 8'h00;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_req_s;

  typedef struct packed {
    logic enable;
    logic prescale;
    logic [7:0] reload;
    logic [7:0] window;
  } wdt_cfg_s;

endpackage : sfr_map_pkg

// file: verilog/sfr_byte_reg.sv
// One byte-wide SFR with writable mask and constant read bits
`timescale 1ns/10ps
`default_nettype none
module sfr_byte_reg
  import sfr_map_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff,
  parameter logic [7:0] FILL = 8'h00
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic WR,
  input wire logic [7:0] WDATA,
  output logic [7:0] VALUE
);

  logic [7:0] store_reg;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      store_reg <= RESET_VALUE & WRITE_MASK;
    end else if (WR) begin
      store_reg <= WDATA & WRITE_MASK;
    end
  end

  // Unimplemented bits read as their fixed level
  assign VALUE = (store_reg & WRITE_MASK) | (FILL & ~WRITE_MASK);

endmodule : sfr_byte_reg
`default_nettype wire

// file: test/sfr_map_sva.sv
// Concurrent checks of the SFR map at its top-level ports
`timescale 1ns/10ps
`default_nettype none
module sfr_map_sva
  import sfr_map_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire sfr_req_s SFR_REQ,
  input wire logic EXT_HIT,
  input wire logic [7:0] EXT_RDATA,
  input wire logic [15:0] WDT_COUNT,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_MAP_SELECT,
  input wire logic WDT_REFRESH
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  logic refresh_req;
  logic rd_only;
  assign refresh_req = SFR_REQ.wr && SFR_REQ.addr == 8'hbb && SFR_REQ.wdata[1] && SFR_MAP_SELECT;
  assign rd_only = SFR_REQ.rd && !SFR_REQ.wr && !EXT_HIT;

  AST_LOW_ADDR_ZERO:
    assert property (rd_only && SFR_REQ.addr < 8'h80 |=> SFR_RDATA == 8'h00)
    else $error("read below the SFR range returned data");
  AST_MAP_FOLLOWS_WRITE:
    assert property (SFR_REQ.wr && SFR_REQ.addr == 8'h8f |=> SFR_MAP_SELECT == $past(SFR_REQ.wdata[0]))
    else $error("map select did not follow the control write");
  AST_CONTROL_READ:
    assert property (rd_only && SFR_REQ.addr == 8'h8f
      |=> (SFR_RDATA & 8'hfa) == 8'h00 && SFR_RDATA[0] == $past(SFR_MAP_SELECT))
    else $error("control read shows wrong bits");
  AST_KEEP_BIT:
    assert property (SFR_REQ.wr && SFR_REQ.addr == 8'h8f ##1 rd_only && SFR_REQ.addr == 8'h8f
      |=> SFR_RDATA[2] == $past(SFR_REQ.wdata[2], 2))
    else $error("control bit 2 did not read back");
  AST_WDT_HIDDEN:
    assert property (rd_only && !SFR_MAP_SELECT && SFR_REQ.addr inside {[8'hbb:8'hbf]}
      |=> SFR_RDATA == 8'h00)
    else $error("watchdog group answered in the standard area");
  AST_WDT_COUNT_LOW:
    assert property (rd_only && SFR_MAP_SELECT && SFR_REQ.addr == 8'hbe
      |=> SFR_RDATA == $past(WDT_COUNT[7:0]))
    else $error("watchdog count low read wrong");
  AST_REFRESH_PULSE:
    assert property (refresh_req |=> WDT_REFRESH)
    else $error("refresh write gave no pulse");
  AST_REFRESH_CAUSE:
    assert property (WDT_REFRESH |-> $past(refresh_req))
    else $error("refresh pulse without a refresh write");
  AST_PORT_HIDDEN:
    assert property (rd_only && SFR_MAP_SELECT && SFR_REQ.addr == 8'h80 |=> SFR_RDATA == 8'h00)
    else $error("port register answered in the mapped area");
  AST_CORE_MERGE:
    assert property (SFR_REQ.rd && !SFR_REQ.wr && EXT_HIT && SFR_REQ.addr inside {[8'hc0:8'hf3]}
      |=> SFR_RDATA == $past(EXT_RDATA))
    else $error("core-held register read wrong");

  COV_REFRESH: cover property (refresh_req ##1 WDT_REFRESH);
  COV_MAP_RISE: cover property ($rose(SFR_MAP_SELECT));
  COV_CORE_READ: cover property (SFR_REQ.rd && EXT_HIT);
endmodule : sfr_map_sva

bind sfr_address_extension_map sfr_map_sva i_sfr_map_sva (.CLOCK, .RST, .SFR_REQ, .EXT_HIT,
  .EXT_RDATA, .WDT_COUNT, .SFR_RDATA, .SFR_MAP_SELECT, .WDT_REFRESH);
`default_nettype wire

// file: test/sfr_core_model.sv
// Processor-core side: issues one SFR access per cycle, owns the accumulator
`timescale 1ns/10ps
`default_nettype none
module sfr_core_model
  import sfr_map_pkg::*;
(
  input wire logic CLOCK,
  input wire logic [7:0] ACC,
  input wire logic [7:0] RDATA,
  output var sfr_req_s REQ,
  output logic EXT_HIT,
  output logic [7:0] EXT_RDATA
);
  // Accumulator owns E0h; bus shows garbage when not selected
  assign EXT_HIT = (REQ.addr == 8'he0);
  assign EXT_RDATA = EXT_HIT ? ACC : ~ACC;

  initial REQ = '0;

  // Called at a falling edge; request waits for one rising edge and stands until the next call
  task automatic access(input logic [7:0] a, input logic [7:0] d, input bit w, input bit r,
                        output logic [7:0] q);
    REQ = '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge CLOCK);
    #1 q = RDATA;
  endtask : access
endmodule : sfr_core_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench of the SFR map against a behavioural register model
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  import sfr_map_pkg::*;
  logic clock, rst, ext_hit, map_sel, refresh, pw_in, mon_st;
  logic [7:0] ext_rdata, rdata, acc, mon_rx, mon_ctl, bp_sel, bp_dat;
  logic [15:0] cnt_in;
  logic [95:0] port_regs;
  sfr_req_s req;
  wdt_cfg_s wdt_cfg;
  int failures = 0, check_count = 0, cycles = 0, seed = 32'h92a53f8e;
  int sys, mp, pg, wctl, rl, wn, rf, pw, k, mon, bps, bpd;
  int prt[PORT_REG_COUNT];
  int slot[4];
  int addrs[22] = '{'h80, 'h86, 'h90, 'h91, 'ha0, 'ha1, 'hb0, 'hb1, 'hb2, 'h8f,
                    'hbb, 'hbc, 'hbd, 'hbe, 'hbf, 'he0, 'h85, 'h10,
                    'hf4, 'hf5, 'hf6, 'hf7};

  sfr_address_extension_map i_sfr_address_extension_map (.CLOCK(clock), .RST(rst),
    .SFR_REQ(req), .EXT_HIT(ext_hit), .EXT_RDATA(ext_rdata), .WDT_COUNT(cnt_in),
    .WDT_PREWARN(pw_in), .MON_STATUS_SEL(mon_st), .MON_RX_DATA(mon_rx), .SFR_RDATA(rdata),
    .SFR_MAP_SELECT(map_sel), .PORT_REGS(port_regs), .WDT_CFG(wdt_cfg), .WDT_REFRESH(refresh),
    .MON_CONTROL(mon_ctl), .BP_SELECT(bp_sel), .BP_DATA(bp_dat));
  sfr_core_model i_sfr_core_model (.CLOCK(clock), .ACC(acc), .RDATA(rdata), .REQ(req),
    .EXT_HIT(ext_hit), .EXT_RDATA(ext_rdata));

  // ----------------------------------------------------------------
  // Register model
  // ----------------------------------------------------------------
  function automatic int exp_rd(int a);
    exp_rd = 0;
    if (a == 'h8f) exp_rd = sys;
    else if (a == 'he0) exp_rd = acc;
    else if (a == 'hf4) exp_rd = (mon & 'he5) | (mon_st << 4);
    else if (a == 'hf5) exp_rd = mon_rx;
    else if (a == 'hf6) exp_rd = bps;
    else if (a == 'hf7) exp_rd = bpd;
    else if (mp == 1 && a == 'hbb) exp_rd = (wctl & 5) | (pw << 4) | (rf << 1);
    else if (mp == 1 && a == 'hbc) exp_rd = rl;
    else if (mp == 1 && a == 'hbd) exp_rd = wn;
    else if (mp == 1 && a == 'hbe) exp_rd = cnt_in[7:0];
    else if (mp == 1 && a == 'hbf) exp_rd = cnt_in[15:8];
    else if (mp == 0 && a == 'hb2) exp_rd = pg;
    else if (mp == 0) begin
      for (int i = 0; i < PORT_REG_COUNT; i++) begin
        if (PORT_OFFSET[i] == a && PORT_PAGE_OF[i] == pg) exp_rd = (prt[i] & PORT_MASK[i]) | PORT_FILL[i];
      end
    end
  endfunction : exp_rd

  function automatic void mdl_wr(int a, int d);
    if (a == 'h8f) begin
      sys = d & 5;
      mp = d & 1;
    end
    else if (a == 'hf4) begin
      mon = (mon & 'h05) | (d & 'he0);
      if ((d & 8) != 0) mon = (mon & 'hfb) | (d & 4);
      if ((d & 2) != 0) mon = (mon & 'hfe) | (d & 1);
    end
    else if (a == 'hf6) begin
      if ((d & 8) != 0) bps = d & 7;
    end
    else if (a == 'hf7) bpd = d;
    else if (mp == 1 && a == 'hbb) wctl = d;
    else if (mp == 1 && a == 'hbc) rl = d;
    else if (mp == 1 && a == 'hbd) wn = d;
    else if (mp == 0 && a == 'hb2) begin
      if (((d >> 6) & 3) == 2) slot[(d >> 3) & 3] = pg;
      pg = (((d >> 6) & 3) == 3) ? slot[(d >> 3) & 3] : d & 7;
    end
    else if (mp == 0) begin
      for (int i = 0; i < PORT_REG_COUNT; i++) begin
        if (PORT_OFFSET[i] == a && PORT_PAGE_OF[i] == pg) prt[i] = d;
      end
    end
  endfunction : mdl_wr

  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  task automatic op(input int a, input int d, input bit w, input bit r);
    logic [7:0] q;
    int e;
    int rf_e;
    @(negedge clock);
    cnt_in = 16'($random(seed));
    pw_in = 1'($random(seed));
    mon_st = ~pw_in;
    mon_rx = cnt_in[15:8];
    acc = 8'($random(seed));
    pw = pw_in;
    e = exp_rd(a);
    rf_e = (w && a == 'hbb && (d & 2) != 0 && mp == 1) ? 1 : 0;
    i_sfr_core_model.access(8'(a), 8'(d), w, r, q);
    if (r) `CHK("read data", e, q)
    `CHK("refresh", rf_e, refresh)
    if (w) mdl_wr(a, d);
    rf = rf_e;
    `CHK("map select", mp, map_sel)
    `CHK("watchdog config", ((wctl & 4) << 15) | ((wctl & 1) << 16) | (rl << 8) | wn, wdt_cfg)
    `CHK("monitor control", (mon & 'he5) | (mon_st << 4), mon_ctl)
    `CHK("breakpoint select", bps, bp_sel)
    `CHK("breakpoint data", bpd, bp_dat)
    for (int i = 0; i < PORT_REG_COUNT; i++) begin
      `CHK("port reg", (prt[i] & PORT_MASK[i]) | PORT_FILL[i], port_regs[i*8 +: 8])
    end
  endtask : op

  task automatic do_reset;
    logic [7:0] q;
    @(negedge clock);
    rst = 1;
    // Idle the bus so no stale request replays after release
    i_sfr_core_model.access(8'h00, 8'h00, 1'b0, 1'b0, q);
    repeat (2) @(negedge clock);
    rst = 0;
    {sys, mp, pg, wctl, rl, wn, rf, mon, bps, bpd} = {32'd4, 288'd0};
    foreach (prt[i]) prt[i] = PORT_RESET[i];
    foreach (slot[i]) slot[i] = 0;
    op('h8f, 0, 0, 1);
  endtask : do_reset

  task automatic random_ops(input int n);
    int a;
    int d;
    for (int j = 0; j < n; j++) begin
      a = addrs[($random(seed) & 32'h7fffffff) % 22];
      d = $random(seed) & 255;
      if (a == 'h8f) d = (d & 1) | 4;
      if (a == 'hb2) d = d & (((d & 'h80) != 0) ? 'hdf : 'h01);
      k = $random(seed) & 1;
      op(a, d, k[0], !k[0]);
    end
  endtask : random_ops

  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    {rst, pw_in, mon_st, mon_rx, cnt_in, acc} = {1'b1, 34'd0};
    do_reset();
    op('h8f, 'hfa, 1, 0);
    op('h8f, 0, 0, 1);
    op('h8f, 'h05, 1, 0);
    op('h8f, 0, 0, 1);
    op('h80, 0, 0, 1);
    op('hbb, 'h07, 1, 0);
    op('hbb, 0, 0, 1);
    op('hbe, 0, 0, 1);
    op('h8f, 'h04, 1, 0);
    op('hbc, 0, 0, 1);
    op('hb2, 1, 1, 0);
    op('h80, 0, 0, 1);
    op('h10, 'h5a, 1, 0);
    op('he0, 0, 0, 1);
    random_ops(400);
    do_reset();
    random_ops(300);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
